// ---- src/spi_rw_cfg.svh ----
// Constants of the SPI register read and write block: field positions,
// command codes, reset values and the link framing figures.
// Assumes inclusion by bare name from the package and the bench top.
`ifndef SPI_RW_CFG_SVH
`define SPI_RW_CFG_SVH

// Frame length and field positions inside a 32-bit frame.
`define FRAME_BITS 32
`define BIT_COUNT_WIDTH 6
`define CMD_HI 31
`define CMD_LO 28
`define ADDR_HI 23
`define ADDR_LO 16
`define DATA_HI 15
`define DATA_LO 8
`define CRC_HI 7
`define CRC_LO 0

// Command codes.
`define CMD_READ 4'hc
`define CMD_WRITE 4'h8

// Head byte of the error response.
`define ERR_HEAD 8'h0c

// Register space and reset value of every byte register.
`define REG_COUNT 256
`define REG_RESET 8'h00

// Address of the lock and write-control register and its reset-control bits.
`define LOCK_REG_ADDR 8'h14
`define LOCK_RESET_MASK 8'h03

// Frame check polynomial and seed.
`define CRC_POLY 8'h2f
`define CRC_SEED 8'hff

// Response held before the first command arrives.
`define TX_RESET 32'h0000_0000

`endif

// ---- src/spi_rw_pkg.sv ----
// Types and the frame check function shared by the SPI register block.
// Assumes spi_rw_cfg.svh is on the include path.
`include "spi_rw_cfg.svh"

package spi_rw_pkg;

  // Kinds of answer the block can queue for the next frame.
  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_NORMAL,
    RESP_ERROR
  } resp_kind_type;

  typedef logic [`FRAME_BITS-1:0] frame_type;
  typedef logic [7:0] byte_type;

  // Bitwise 8-bit CRC over the upper 24 bits of a frame, MSB first.
  function automatic byte_type crc8(input logic [23:0] body);
    byte_type acc;
    logic fb;
    acc = `CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      fb = acc[7] ^ body[i];
      acc = {acc[6:0], 1'b0};
      if (fb) begin
        acc = acc ^ `CRC_POLY;
      end
    end
    return acc;
  endfunction

endpackage

// ---- src/frame_if.sv ----
// Carrier between the serial shifter and the command core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface frame_if;
  import spi_rw_pkg::*;
  frame_type txWord;
  frame_type rxWord;
  logic frameDone;
  logic frameFull;

  modport shifter (input txWord, output rxWord, output frameDone, output frameFull);
  modport core (output txWord, input rxWord, input frameDone, input frameFull);
endinterface

// ---- src/spi_frame_shifter.sv ----
// Serial shifter of the SPI slave port: samples on rising and shifts out on
// falling serial clock edges, detected in the system clock domain.
// Assumes the pins are synchronous to mclk and much slower than it.
`timescale 1ns/10ps

module spi_frame_shifter
  import spi_rw_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins.
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selN,
  output logic miso,
  // Frame carrier.
  frame_if.shifter link
);

  logic sclkPrev, selPrev;
  logic next_sclkPrev, next_selPrev;
  frame_type rxShift, txShift, rxHold;
  frame_type next_rxShift, next_txShift, next_rxHold;
  logic [`BIT_COUNT_WIDTH-1:0] bitCount, next_bitCount;
  logic done, full, next_done, next_full;

  // Edge detection, shifting and frame closing.
  always_comb begin
    next_sclkPrev = sclk;
    next_selPrev = selN;
    next_rxShift = rxShift;
    next_txShift = txShift;
    next_rxHold = rxHold;
    next_bitCount = bitCount;
    next_done = 1'b0;
    next_full = full;
    if (selPrev && !selN) begin
      next_txShift = link.txWord;
      next_rxShift = '0;
      next_bitCount = '0;
    end else if (!selN) begin
      if (!sclkPrev && sclk) begin
        next_rxShift = {rxShift[`FRAME_BITS-2:0], mosi};
        if (bitCount != '1) begin
          next_bitCount = bitCount + 1'b1;
        end
      end else if (sclkPrev && !sclk) begin
        next_txShift = {txShift[`FRAME_BITS-2:0], 1'b0};
      end
    end
    // Select rising closes the frame; clock and data are ignored while high.
    if (!selPrev && selN) begin
      next_done = 1'b1;
      next_rxHold = rxShift;
      next_full = (bitCount == `BIT_COUNT_WIDTH'(`FRAME_BITS));
    end
  end

  // State registers.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev <= 1'b0;
      selPrev <= 1'b1;
      rxShift <= '0;
      txShift <= '0;
      rxHold <= '0;
      bitCount <= '0;
      done <= 1'b0;
      full <= 1'b0;
    end else begin
      sclkPrev <= next_sclkPrev;
      selPrev <= next_selPrev;
      rxShift <= next_rxShift;
      txShift <= next_txShift;
      rxHold <= next_rxHold;
      bitCount <= next_bitCount;
      done <= next_done;
      full <= next_full;
    end
  end

  // Outputs straight from flip-flops.
  assign miso = txShift[`FRAME_BITS-1];
  assign link.rxWord = rxHold;
  assign link.frameDone = done;
  assign link.frameFull = full;

endmodule

// ---- src/spi_register_read_write.sv ----
// Register read and write command handling of the 32-bit SPI slave port.
// Assumes a master on the serial pins and sensor logic on the plain ports.
`timescale 1ns/10ps

// Operation
// - Read request code is 1100 at top.
// - Read selects byte pair by upper seven bits.
// - Odd byte high, even byte low in reply.
// - Read answers normally only without framing, output errors.
// - Read data taken when select rises.
// - Reply echoes command reordered, giving 0110.
// - Two status bits follow echo, then zeros.
// - Write stores data byte at full address.
// - Write reply returns updated register pair.
// - Write needs no framing error, lock clear.
// - Reset-control bits writable even when locked.
// - Refused write changes nothing, returns error reply.
// - Write commits only after its frame ends.
// - Read-only target unchanged, reply still normal.
// - 32-bit frames, MSB first, reply next frame.
// - Clock idles low, sample rising, shift falling.
// - Ignore clock and data while deselected.
module spi_register_read_write
  import spi_rw_pkg::*;
#(
  parameter logic [`REG_COUNT-1:0] READ_ONLY_MASK = '0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // SPI slave pins.
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selN,
  output logic miso,
  output logic misoOeN,
  // Device state feeding the command checks and the answer head.
  input wire logic initDoneLock,
  input wire logic misoError,
  input wire logic [1:0] basicStatusField,
  // Results towards the device.
  output logic [1:0] resetCtrl,
  output logic writeStrobe,
  output logic [7:0] writeAddr,
  output logic [7:0] writeData,
  output logic frameError,
  output logic [1:0] lastResp
);

  frame_if link ();

  // Serial side of the port.
  spi_frame_shifter shifter (
    .mclk(mclk),
    .reset_n(reset_n),
    .sclk(sclk),
    .mosi(mosi),
    .selN(selN),
    .miso(miso),
    .link(link.shifter)
  );

  // The output pin is driven only while the master selects the device.
  assign misoOeN = selN;

  // Field split of the received command.
  logic [3:0] cmd;
  logic [7:0] regAddrField;
  logic [7:0] dataIn;
  logic [7:0] crcIn;
  logic crcBad;
  logic badFrame;
  logic isRead;
  logic isWrite;
  assign cmd = link.rxWord[`CMD_HI:`CMD_LO];
  assign regAddrField = link.rxWord[`ADDR_HI:`ADDR_LO];
  assign dataIn = link.rxWord[`DATA_HI:`DATA_LO];
  assign crcIn = link.rxWord[`CRC_HI:`CRC_LO];
  assign isRead = (cmd == `CMD_READ);
  assign isWrite = (cmd == `CMD_WRITE);

  // A short, long or corrupted frame counts as a framing error.
  assign crcBad = (crc8(link.rxWord[`FRAME_BITS-1:`CRC_HI+1]) != crcIn);
  assign badFrame = !link.frameFull || crcBad;

  // Address of the even byte of the pair; bit 0 plays no part in selection.
  function automatic logic [7:0] pairBase(input logic [7:0] a);
    return {a[7:1], 1'b0};
  endfunction

  // Byte register space and the response queued for the next frame.
  byte_type regs [`REG_COUNT];
  byte_type next_regs [`REG_COUNT];
  frame_type txWord, next_txWord;
  logic next_writeStrobe;
  logic [7:0] next_writeAddr;
  logic [7:0] next_writeData;
  logic next_frameError;
  resp_kind_type resp, next_resp;

  // Working values of the command decoder.
  logic [23:0] body;
  byte_type hiByte;
  byte_type loByte;
  byte_type mergedByte;
  logic [3:0] echo;
  logic writeAllowed;
  logic lockTarget;

  // Command decoder: checks, write commit at frame end and response build.
  always_comb begin
    body = '0;
    hiByte = '0;
    loByte = '0;
    mergedByte = '0;
    echo = '0;
    writeAllowed = 1'b0;
    lockTarget = 1'b0;
    next_regs = regs;
    next_txWord = txWord;
    next_writeStrobe = 1'b0;
    next_writeAddr = writeAddr;
    next_writeData = writeData;
    next_frameError = frameError;
    next_resp = resp;
    // Nothing happens before the frame that carries the command has closed.
    if (link.frameDone) begin
      next_frameError = badFrame;
      echo = {cmd[0], cmd[3:1]};
      lockTarget = (regAddrField == `LOCK_REG_ADDR);
      // Lock blocks every write except one aimed at the reset-control bits.
      writeAllowed = !badFrame && (!initDoneLock || lockTarget);
      if (isWrite && writeAllowed) begin
        if (!READ_ONLY_MASK[regAddrField]) begin
          if (initDoneLock) begin
            // Locked: only the reset-control bits take the new value.
            mergedByte = (regs[regAddrField] & ~`LOCK_RESET_MASK)
              | (dataIn & `LOCK_RESET_MASK);
          end else begin
            mergedByte = dataIn;
          end
          next_regs[regAddrField] = mergedByte;
          next_writeStrobe = 1'b1;
          next_writeAddr = regAddrField;
          next_writeData = mergedByte;
        end
      end
      // Pair contents after any commit, so a write answers with new data.
      hiByte = next_regs[pairBase(regAddrField) | 8'h01];
      loByte = next_regs[pairBase(regAddrField)];
      if (isRead && !badFrame && !misoError) begin
        body = {echo, basicStatusField, 2'b00, hiByte, loByte};
        next_resp = RESP_NORMAL;
      end else if (isWrite && writeAllowed) begin
        body = {echo, basicStatusField, 2'b00, hiByte, loByte};
        next_resp = RESP_NORMAL;
      end else if (isRead || isWrite) begin
        // Refused command: registers untouched, error answer queued.
        body = {`ERR_HEAD, hiByte, loByte};
        next_resp = RESP_ERROR;
      end else begin
        // Commands outside this block get the error answer without data.
        body = {`ERR_HEAD, 16'h0000};
        next_resp = RESP_ERROR;
      end
      // The answer goes out in the following frame, check byte last.
      next_txWord = {body, crc8(body)};
    end
  end

  // Register space, response word and result ports.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs[i] <= `REG_RESET;
      end
      txWord <= `TX_RESET;
      writeStrobe <= 1'b0;
      writeAddr <= '0;
      writeData <= '0;
      frameError <= 1'b0;
      resp <= RESP_NONE;
    end else begin
      regs <= next_regs;
      txWord <= next_txWord;
      writeStrobe <= next_writeStrobe;
      writeAddr <= next_writeAddr;
      writeData <= next_writeData;
      frameError <= next_frameError;
      resp <= next_resp;
    end
  end

  // Response handed to the shifter; it loads it when select falls.
  assign link.txWord = txWord;

  // Reset-control bits of the lock register drive the device resets.
  assign resetCtrl = regs[`LOCK_REG_ADDR][1:0];

  // Kind of the answer waiting for the next frame.
  assign lastResp = resp;

endmodule

// ---- bench/spi_register_read_write_props.sv ----
// Checker on the ports of the SPI register read and write block.
// Assumes it is bound into every instance of that block.
`timescale 1ns/10ps

module spi_rw_props (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins.
  input wire logic sclk,
  input wire logic selN,
  input wire logic miso,
  input wire logic misoOeN,
  // Device side.
  input wire logic initDoneLock,
  input wire logic [1:0] resetCtrl,
  input wire logic writeStrobe,
  input wire logic [7:0] writeAddr,
  input wire logic [7:0] writeData,
  input wire logic frameError,
  input wire logic [1:0] lastResp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Pin behaviour inside and outside frames, and when the answer kind changes.
  property p_oe; misoOeN == selN; endproperty
  a_oe: assert property (p_oe) else $error("output enable not following select");
  property p_hold; !selN && sclk && $past(sclk, 2) |-> $stable(miso); endproperty
  a_hold: assert property (p_hold) else $error("data out moved while clock high");
  property p_resp; $changed(lastResp) |-> selN; endproperty
  a_resp: assert property (p_resp) else $error("answer kind changed inside a frame");

  // Commit timing and outcome of writes, and the answer to a framing error.
  property p_pulse; writeStrobe |=> !writeStrobe; endproperty
  a_pulse: assert property (p_pulse) else $error("write strobe longer than a cycle");
  property p_late; writeStrobe |-> selN && $past(selN, 2); endproperty
  a_late: assert property (p_late) else $error("write committed before frame end");
  property p_okw; writeStrobe |-> lastResp == 2'd1 && !frameError; endproperty
  a_okw: assert property (p_okw) else $error("write committed with error answer");
  property p_err; frameError |-> lastResp == 2'd2; endproperty
  a_err: assert property (p_err) else $error("framing error without error answer");
  property p_lock; writeStrobe && initDoneLock |-> writeAddr == 8'h14; endproperty
  a_lock: assert property (p_lock) else $error("locked write went through");
  property p_rc;
    $changed(resetCtrl) |-> writeStrobe && writeAddr == 8'h14 && resetCtrl == writeData[1:0];
  endproperty
  a_rc: assert property (p_rc) else $error("reset control changed without its write");

  // Main scenarios reached.
  c_write: cover property (writeStrobe);
  c_err: cover property (lastResp == 2'd2);
  c_lock: cover property (writeStrobe && initDoneLock);
endmodule

bind spi_register_read_write spi_rw_props i_props (.*);

// ---- bench/spi_master_model.sv ----
// Serial master that sends one command frame of up to 32 bits per call.
// Assumes the system clock runs far faster than the serial clock made here.
`timescale 1ns/10ps

module spi_master_model
  import spi_rw_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic sclk,
  output logic mosi,
  output logic selN,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    selN = 1'b1;
  end

  // Shifts MSB first; a count below 32 breaks framing on purpose.
  task automatic xfer(input frame_type cmd, input int nbits, output frame_type resp);
    resp = '0;
    @(posedge mclk);
    selN <= 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      mosi <= cmd[i];
      repeat (6) @(posedge mclk);
      sclk <= 1'b1;
      resp[i] = miso;
      repeat (6) @(posedge mclk);
      sclk <= 1'b0;
    end
    // Released data line shows the inverse of its last bit.
    mosi <= ~cmd[32 - nbits];
    selN <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// ---- bench/spi_register_read_write_tb_top.sv ----
// Self-checking bench of the SPI register block, driven through a master model.
// Assumes package, design, checker and master model are compiled first.
`timescale 1ns/10ps
`include "spi_rw_cfg.svh"

module spi_register_read_write_tb_top;
  import spi_rw_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic initDoneLock = 1'b0;
  logic misoError = 1'b0;
  logic [1:0] basicStatusField = 2'b10;
  logic sclk, mosi, selN, miso, misoOeN, writeStrobe, frameError;
  logic [1:0] resetCtrl, lastResp;
  logic [7:0] writeAddr, writeData;
  byte_type regs [256] = '{default: 8'h00};
  frame_type pend = `TX_RESET;
  frame_type rsp;
  int error_cnt = 0;
  int total_checks = 0;

  // System clock.
  always #5 mclk = ~mclk;

  // Byte register 0x20 is read-only.
  spi_register_read_write #(.READ_ONLY_MASK(256'h1 << 8'h20)) i_dut (.*);
  spi_master_model i_master (.*);

  // Frame with its check byte appended.
  function automatic frame_type fr(input logic [23:0] b);
    byte_type c;
    c = `CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? `CRC_POLY : 8'h00);
    end
    return {b, c};
  endfunction

  // Expected answer with the byte pair around address a.
  function automatic frame_type pr(input byte_type h, input byte_type a);
    return fr({h, regs[a | 8'h01], regs[a & 8'hfe]});
  endfunction

  // Head byte of a normal answer.
  function automatic byte_type hd(input logic [3:0] e);
    return {e, basicStatusField, 2'b00};
  endfunction

  // Compares a result with its expected value.
  task automatic chk(input frame_type got, input frame_type exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Sends one command and checks the answer to the one before.
  task automatic go(input logic [3:0] c, input byte_type a, input byte_type d,
                    input int n = 32, input frame_type x = 0);
    i_master.xfer(fr({c, 4'h0, a, d}) ^ x, n, rsp);
    chk(rsp, pend & (32'hffff_ffff << (32 - n)));
  endtask

  // Writes, then reads that straddle a pending write.
  task automatic t_rw;
    go(4'h8, 8'h03, 8'h55);
    regs[3] = 8'h55;
    pend = pr(hd(4'h4), 8'h03);
    go(4'h8, 8'h02, 8'ha6);
    regs[2] = 8'ha6;
    pend = pr(hd(4'h4), 8'h02);
    go(4'hc, 8'h03, 8'h00);
    pend = pr(hd(4'h6), 8'h02);
    go(4'h8, 8'h03, 8'h77);
    chk({16'h0, writeAddr, writeData}, 32'h0000_0377);
    regs[3] = 8'h77;
    pend = pr(hd(4'h4), 8'h03);
    go(4'hc, 8'h02, 8'h00);
    pend = pr(hd(4'h6), 8'h03);
    $display("test rw done");
  endtask

  // Writes while the init lock is set.
  task automatic t_lock;
    initDoneLock <= 1'b1;
    go(4'h8, 8'h05, 8'h11);
    pend = pr(`ERR_HEAD, 8'h05);
    go(4'h8, 8'h14, 8'hff);
    regs[8'h14] = 8'h03;
    pend = pr(hd(4'h4), 8'h14);
    chk({30'h0, resetCtrl}, 32'h0000_0003);
    initDoneLock <= 1'b0;
    go(4'hc, 8'h04, 8'h00);
    pend = pr(hd(4'h6), 8'h04);
    $display("test lock done");
  endtask

  // Write to a read-only byte.
  task automatic t_ro;
    go(4'h8, 8'h20, 8'h99);
    pend = pr(hd(4'h4), 8'h20);
    go(4'hc, 8'h20, 8'h00);
    pend = pr(hd(4'h6), 8'h20);
    $display("test ro done");
  endtask

  // Bad check byte, short frame and output-line error.
  task automatic t_err;
    go(4'h8, 8'h06, 8'h44, 32, 32'h1);
    chk({30'h0, frameError, writeStrobe}, 32'h0000_0002);
    chk({30'h0, lastResp}, 32'h0000_0002);
    pend = pr(`ERR_HEAD, 8'h06);
    go(4'h8, 8'h06, 8'h44, 16);
    pend = pr(`ERR_HEAD, 8'h06);
    misoError <= 1'b1;
    go(4'hc, 8'h07, 8'h00);
    pend = pr(`ERR_HEAD, 8'h07);
    misoError <= 1'b0;
    go(4'hc, 8'h06, 8'h00);
    pend = pr(hd(4'h6), 8'h06);
    go(4'hc, 8'h00, 8'h00);
    $display("test err done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after reset.
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_rw();
    t_lock();
    t_ro();
    t_err();
    wrap_up();
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
endmodule
